// file: hw/smc_pkg.sv
// constants, carrier types and helpers for the spi mode control block
package smc_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0]  SMC_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  SMC_DIV_OFS    = 8'h04;
  localparam logic [7:0]  SMC_TXD_OFS    = 8'h08;
  localparam logic [7:0]  SMC_RXD_OFS    = 8'h0C;
  localparam logic [7:0]  SMC_STAT_OFS   = 8'h10;

  // ==========================================================
  // spi_mode_control fields
  localparam int          SMC_MODE_BIT   = 15;
  localparam int          SMC_CLOCK_PHASE_SELECT_BIT   = 13;
  localparam int          SMC_CLOCK_POLARITY_SELECT_BIT   = 12;
  localparam int          SMC_SSEN_BIT   = 8;
  localparam int          SMC_SETUP_LSB  = 4;
  localparam int          SMC_GAP_LSB    = 0;
  localparam logic [15:0] SMC_CTRL_WMASK = 16'hB133;
  localparam logic [15:0] SMC_CTRL_RST   = 16'h0000;

  // ==========================================================
  // divider, data and status
  localparam int          SMC_DIV_W      = 10;
  localparam logic [9:0]  SMC_DIV_RST    = 10'h000;
  localparam int          SMC_DATA_W     = 16;
  localparam int          SMC_EDGES      = 2 * SMC_DATA_W;
  localparam int          SMC_STAT_PEND  = 0;
  localparam int          SMC_STAT_BUSY  = 1;
  localparam int          SMC_STAT_RXV   = 2;

  // ==========================================================
  // types
  typedef struct packed {
    logic                  clock_phase_select;
    logic                  clock_polarity_select;
    logic                  ss_en;
    logic [1:0]            setup;
    logic [1:0]            gap;
    logic [SMC_DIV_W-1:0]  div;
    logic [SMC_DATA_W-1:0] data;
  } smc_req_type;

  typedef enum logic [2:0] {
    L_IDLE, L_SETUP, L_SHIFT, L_HOLD, L_GAP
  } smc_link_state_type;

  // ==========================================================
  // timing in half serial clock periods, and the apb byte lane mask
  function automatic logic [2:0] setup_halves(input logic clock_phase_select, input logic [1:0] code);
    setup_halves = {1'b0, code} + {2'b00, ~clock_phase_select};
  endfunction : setup_halves

  function automatic logic [2:0] hold_halves(input logic clock_phase_select, input logic [1:0] code);
    hold_halves = {1'b0, code} + {2'b00, clock_phase_select};
  endfunction : hold_halves

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

endpackage : smc_pkg

// file: hw/smc_spi_master.sv
// apb register slave and spi master engine for the serial codec unit
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps

// Behaviour
// [R1] mode bit 15 low keeps the spi engine idle; high makes it an spi master
// [R2] clock phase bit 13 picks first or second serial clock edge for sampling
// [R3] clock polarity bit 12 picks idle-low or idle-high serial clock
// [R4] select enable bit 8 decides whether slave select zero is driven low
// [R5] phase 0: setup 0.5/1/1.5/2 and hold 0/0.5/1/1.5 clocks per code
// [R6] phase 1: setup 0/0.5/1/1.5 and hold 0.5/1/1.5/2 clocks per code
// [R7] frame gap code gives 0 to 3 idle serial clocks between frames
// [R8] gap code 00 chains frames back to back with select held low
// [R9] reserved control bits read zero; software writes zero there
// [R10] control register is 16 bits, read/write, resets to all zero
// [R11] serial clock comes from a divider with ratios 1/1 to 1/1024
// [R12] slave keeps data stable at the sampling edge and ignores clock unselected
module smc_spi_master
  import smc_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // spi link
  input  wire logic        link_clk,
  output logic             sck,
  output logic             slave_select_zero_n,
  output logic             mosi,
  input  wire logic        miso
);

  // ==========================================================
  // apb side declarations
  logic [15:0]          ctrl_q;
  logic [SMC_DIV_W-1:0] div_q;
  smc_req_type          req_q;
  logic                 req_tog_q;
  logic [15:0]          rx_data_q;
  logic                 rx_valid_q;
  logic                 done_seen_q;
  logic [31:0]          prdata_q;
  logic [2:0]           st_s1_q;
  logic [2:0]           st_s2_q;
  logic [2:0]           st_s3_q;
  logic [2:0]           st_f_q;
  logic                 acc_wr;
  logic                 acc_rd;
  logic                 setup_rd;
  logic                 mapped;
  logic                 pending;
  logic                 tx_refused;
  logic                 rx_capture;
  logic [31:0]          wmask;
  logic [31:0]          rdata;

  // ==========================================================
  // link side declarations
  logic                 lrst1_q;
  logic                 lrst_n_q;
  logic [2:0]           cs_s1_q;
  logic [2:0]           cs_s2_q;
  logic [2:0]           cs_s3_q;
  logic [2:0]           cs_f_q;
  logic [2:0]           mi_q;
  logic                 miso_f_q;
  smc_link_state_type   st_q;
  smc_req_type          cfg_q;
  smc_req_type          cfg_c;
  logic [SMC_DIV_W-1:0] dcnt_q;
  logic [2:0]           hc_q;
  logic [$clog2(SMC_EDGES)-1:0] ecnt_q;
  logic                 sck_q;
  logic                 ssn_q;
  logic [15:0]          tx_sh_q;
  logic [15:0]          rx_sh_q;
  logic [15:0]          rx_hold_q;
  logic                 ack_tog_q;
  logic                 done_tog_q;
  logic                 mode_l;
  logic                 clock_polarity_select_l;
  logic                 req_l;
  logic                 tick;
  logic                 new_req;
  logic                 accept_idle;
  logic                 accept;
  logic                 chain;
  logic                 do_edge;
  logic                 last_edge;
  logic                 sample_edge;
  logic [2:0]           setup_new;
  logic [2:0]           hold_cur;
  logic [2:0]           gap_halves;

  // ==========================================================
  // apb decode
  assign acc_wr   = psel & penable & pwrite;
  assign acc_rd   = psel & penable & ~pwrite;
  assign setup_rd = psel & ~penable & ~pwrite & (paddr == SMC_RXD_OFS);
  assign mapped   = (paddr == SMC_CTRL_OFS) | (paddr == SMC_DIV_OFS) |
                    (paddr == SMC_TXD_OFS) | (paddr == SMC_RXD_OFS) |
                    (paddr == SMC_STAT_OFS);
  assign wmask    = lane_mask(pstrb);
  assign pending  = req_tog_q != st_f_q[0];
  // a new word is refused while the previous one is not yet taken
  assign tx_refused = (paddr == SMC_TXD_OFS) & pwrite & (pending | ~ctrl_q[SMC_MODE_BIT]);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & (~mapped | tx_refused);
  assign prdata   = prdata_q;

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      SMC_CTRL_OFS: rdata = {16'h0000, ctrl_q};
      SMC_DIV_OFS:  rdata = {22'h00_0000, div_q};
      SMC_TXD_OFS:  rdata = {16'h0000, req_q.data};
      SMC_RXD_OFS:  rdata = {16'h0000, rx_data_q};
      SMC_STAT_OFS: rdata = {29'h0000_0000, rx_valid_q, st_f_q[2], pending};
      default:      rdata = 32'h0000_0000;
    endcase
  end

  // read data is latched in the setup phase so it is a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_q <= rdata;
    end
  end

  // ==========================================================
  // control and divider registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= SMC_CTRL_RST; // [R10]
    end else if (acc_wr & (paddr == SMC_CTRL_OFS)) begin
      // reserved bits never store, so they read back zero
      ctrl_q <= ((ctrl_q & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0])) & SMC_CTRL_WMASK; // [R9]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= SMC_DIV_RST;
    end else if (acc_wr & (paddr == SMC_DIV_OFS)) begin
      div_q <= (div_q & ~wmask[9:0]) | (pwdata[9:0] & wmask[9:0]); // [R11]
    end
  end

  // ==========================================================
  // request word: config snapshot plus data, held until taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q     <= '0;
      req_tog_q <= 1'b0;
    end else if (acc_wr & (paddr == SMC_TXD_OFS) & ~tx_refused) begin
      req_q.clock_phase_select  <= ctrl_q[SMC_CLOCK_PHASE_SELECT_BIT];
      req_q.clock_polarity_select  <= ctrl_q[SMC_CLOCK_POLARITY_SELECT_BIT];
      req_q.ss_en <= ctrl_q[SMC_SSEN_BIT];
      req_q.setup <= ctrl_q[SMC_SETUP_LSB+:2];
      req_q.gap   <= ctrl_q[SMC_GAP_LSB+:2];
      req_q.div   <= div_q;
      req_q.data  <= (req_q.data & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      req_tog_q   <= ~req_tog_q;
    end
  end

  // ==========================================================
  // link status back into pclk: {busy, done, ack}
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_s1_q <= 3'h0;
      st_s2_q <= 3'h0;
      st_s3_q <= 3'h0;
      st_f_q  <= 3'h0;
    end else begin
      st_s1_q <= {st_q != L_IDLE, done_tog_q, ack_tog_q};
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
      st_f_q  <= (st_f_q & (st_s2_q ^ st_s3_q)) | (st_s3_q & ~(st_s2_q ^ st_s3_q));
    end
  end

  // ==========================================================
  // received word; capture held off during a pending rx read setup
  assign rx_capture = (st_f_q[1] != done_seen_q) & ~setup_rd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_q   <= 16'h0000;
      done_seen_q <= 1'b0;
    end else if (rx_capture) begin
      rx_data_q   <= rx_hold_q;
      done_seen_q <= st_f_q[1];
    end
  end

  // a new word wins over the clear of a read in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid_q <= 1'b0;
    end else if (rx_capture) begin
      rx_valid_q <= 1'b1;
    end else if (acc_rd & (paddr == SMC_RXD_OFS)) begin
      rx_valid_q <= 1'b0;
    end
  end

  // ==========================================================
  // link reset and synchronisers: {clock_polarity_select, mode, req}
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      lrst1_q  <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      lrst1_q  <= 1'b1;
      lrst_n_q <= lrst1_q;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      cs_s1_q  <= 3'h0;
      cs_s2_q  <= 3'h0;
      cs_s3_q  <= 3'h0;
      cs_f_q   <= 3'h0;
      mi_q     <= 3'h0;
      miso_f_q <= 1'b0;
    end else begin
      cs_s1_q  <= {ctrl_q[SMC_CLOCK_POLARITY_SELECT_BIT], ctrl_q[SMC_MODE_BIT], req_tog_q};
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      cs_f_q   <= (cs_f_q & (cs_s2_q ^ cs_s3_q)) | (cs_s3_q & ~(cs_s2_q ^ cs_s3_q));
      mi_q     <= {mi_q[1:0], miso};
      if (mi_q[1] == mi_q[2]) begin
        miso_f_q <= mi_q[2];
      end
    end
  end

  assign req_l  = cs_f_q[0];
  assign mode_l = cs_f_q[1];
  assign clock_polarity_select_l = cs_f_q[2];

  // ==========================================================
  // link control terms
  assign tick        = dcnt_q == '0; // [R11]
  assign new_req     = mode_l & (req_l != ack_tog_q); // [R1]
  assign accept_idle = (st_q == L_IDLE) & new_req;
  assign cfg_c       = accept_idle ? req_q : cfg_q;
  assign setup_new   = setup_halves(req_q.clock_phase_select, req_q.setup); // [R5] [R6]
  assign hold_cur    = hold_halves(cfg_q.clock_phase_select, cfg_q.setup); // [R5] [R6]
  assign gap_halves  = {cfg_q.gap, 1'b0}; // [R7]
  assign do_edge     = ((st_q == L_SHIFT) & tick) |
                       ((st_q == L_SETUP) & tick & (hc_q == 3'd1)) |
                       (accept_idle & (setup_new == 3'd0));
  assign last_edge   = do_edge & (ecnt_q == ($clog2(SMC_EDGES))'(SMC_EDGES - 1));
  assign chain       = last_edge & (cfg_q.gap == 2'b00) & new_req; // [R8]
  assign accept      = accept_idle | chain;
  assign sample_edge = ecnt_q[0] == cfg_c.clock_phase_select; // [R2]

  // ==========================================================
  // half-period divider
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      dcnt_q <= SMC_DIV_RST;
    end else if (accept) begin
      dcnt_q <= req_q.div;
    end else if (tick) begin
      dcnt_q <= cfg_q.div;
    end else begin
      dcnt_q <= dcnt_q - 1'b1;
    end
  end

  // ==========================================================
  // frame sequencer
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      st_q      <= L_IDLE;
      cfg_q     <= '0;
      hc_q      <= 3'd0;
      ssn_q     <= 1'b1;
      ack_tog_q <= 1'b0;
    end else if (!mode_l) begin
      st_q  <= L_IDLE; // [R1]
      ssn_q <= 1'b1;
    end else begin
      if (accept) begin
        ack_tog_q <= ~ack_tog_q;
        cfg_q     <= req_q;
      end
      case (st_q)
        L_IDLE: begin
          if (accept_idle) begin
            ssn_q <= ~req_q.ss_en; // [R4]
            hc_q  <= setup_new;
            st_q  <= (setup_new == 3'd0) ? L_SHIFT : L_SETUP;
          end
        end
        L_SETUP: begin
          if (tick) begin
            hc_q <= hc_q - 1'b1;
            if (hc_q == 3'd1) begin
              st_q <= L_SHIFT;
            end
          end
        end
        L_SHIFT: begin
          if (last_edge & ~chain) begin
            if (hold_cur == 3'd0) begin
              ssn_q <= 1'b1;
              hc_q  <= gap_halves;
              st_q  <= (gap_halves == 3'd0) ? L_IDLE : L_GAP;
            end else begin
              hc_q <= hold_cur;
              st_q <= L_HOLD;
            end
          end
        end
        L_HOLD: begin
          if (tick) begin
            hc_q <= hc_q - 1'b1;
            if (hc_q == 3'd1) begin
              ssn_q <= 1'b1;
              hc_q  <= gap_halves;
              st_q  <= (gap_halves == 3'd0) ? L_IDLE : L_GAP;
            end
          end
        end
        L_GAP: begin
          if (tick) begin
            hc_q <= hc_q - 1'b1;
            if (hc_q == 3'd1) begin
              st_q <= L_IDLE; // [R7]
            end
          end
        end
        default: begin
          st_q <= L_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // serial clock: idles at polarity, toggles once per edge
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      sck_q <= 1'b0;
    end else if (!mode_l | ((st_q == L_IDLE) & ~accept_idle)) begin
      sck_q <= clock_polarity_select_l; // [R3]
    end else if (accept_idle) begin
      sck_q <= do_edge ? ~req_q.clock_polarity_select : req_q.clock_polarity_select; // [R3]
    end else if (do_edge) begin
      sck_q <= ~sck_q;
    end
  end

  // ==========================================================
  // edge counter and shift registers
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      ecnt_q <= '0;
    end else if (accept_idle & do_edge) begin
      ecnt_q <= ($clog2(SMC_EDGES))'(1);
    end else if (accept) begin
      ecnt_q <= '0;
    end else if (do_edge) begin
      ecnt_q <= ecnt_q + 1'b1;
    end
  end

  // phase 1 presents the first bit on edge 0; a chained phase 1 word waits for
  // that edge, so the old last bit still stands at its sampling edge
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      tx_sh_q <= 16'h0000;
    end else if (accept & ~(chain & req_q.clock_phase_select)) begin
      tx_sh_q <= req_q.data;
    end else if (do_edge & cfg_c.clock_phase_select & (ecnt_q == '0)) begin
      tx_sh_q <= cfg_c.data; // [R2]
    end else if (do_edge & ~sample_edge) begin
      tx_sh_q <= {tx_sh_q[14:0], 1'b0}; // [R2]
    end
  end

  // miso lags four link clocks in the synchroniser, so a half period needs five
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      rx_sh_q <= 16'h0000;
    end else if (do_edge & sample_edge) begin
      rx_sh_q <= {rx_sh_q[14:0], miso_f_q}; // [R2] [R12]
    end
  end

  // finished word stays put until the next frame ends
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      rx_hold_q  <= 16'h0000;
      done_tog_q <= 1'b0;
    end else if (last_edge) begin
      rx_hold_q  <= cfg_q.clock_phase_select ? {rx_sh_q[14:0], miso_f_q} : rx_sh_q;
      done_tog_q <= ~done_tog_q;
    end
  end

  // ==========================================================
  // pins
  assign sck                 = sck_q;
  assign slave_select_zero_n = ssn_q; // [R4]
  assign mosi                = tx_sh_q[15];

endmodule : smc_spi_master

// file: sim/smc_slave_model.sv
// behavioural spi slave that answers the master's frames
`timescale 1ns/1ps
module smc_slave_model (
  // link pins
  input  wire logic        sck,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  output logic             miso,
  // frame format and reply word
  input  wire logic        clock_phase_select,
  input  wire logic        clock_polarity_select,
  input  wire logic [15:0] reply
);
  // ==========================================================
  // shifting
  logic [15:0] rx_q;
  logic [15:0] got[$];
  int          k;
  int          cnt;
  initial begin
    miso = 1'b0;
    k = 15;
    cnt = 0;
  end
  // no pull on this line: released means the inverse of the last bit
  always @(posedge ss_n) miso = (miso === 1'b0);
  always @(negedge ss_n) begin
    cnt = 0;
    k = 15;
    if (!clock_phase_select) begin
      miso = reply[15];
      k = 14;
    end
  end
  // clock edges are ignored while not selected; 1 ns lets select settle first
  always @(sck) begin
    #1;
    if (!ss_n && ((sck != clock_polarity_select) != clock_phase_select)) begin
      rx_q = {rx_q[14:0], mosi};
      cnt++;
      if (cnt == 16) begin
        got.push_back(rx_q);
        cnt = 0;
        k = 15;
      end
    end else if (!ss_n && k >= 0) begin
      miso = reply[k[3:0]];
      k--;
    end
  end
endmodule : smc_slave_model

// file: sim/smc_spi_master_assertions.sv
// assertion checker on the spi mode control block ports
`timescale 1ns/1ps
module smc_spi_master_assertions
  import smc_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // link
  input  wire logic        link_clk,
  input  wire logic        sck,
  input  wire logic        slave_select_zero_n
);
  // ==========================================================
  // shadow of the control register
  localparam logic [15:0] RW_BITS = 16'hB133;
  logic        acc;
  logic [15:0] ctrl_q;
  logic [15:0] seen_q;
  logic [3:0]  stab_q;
  assign acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 16'h0000;
    end else if (acc && pwrite && paddr == SMC_CTRL_OFS) begin
      if (pstrb[0]) ctrl_q[7:0] <= pwdata[7:0] & RW_BITS[7:0];
      if (pstrb[1]) ctrl_q[15:8] <= pwdata[15:8] & RW_BITS[15:8];
    end
  end
  // link side lags the bus, so judge it only after 15 quiet link clocks
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 16'h0000;
      stab_q <= 4'h0;
    end else begin
      seen_q <= ctrl_q;
      stab_q <= (seen_q != ctrl_q) ? 4'h0 : stab_q + {3'h0, stab_q != 4'hF};
    end
  end
  // ==========================================================
  // properties
  property p_ready;
    @(posedge pclk) disable iff (!presetn) psel |-> pready;
  endproperty
  property p_ctrl_rd;
    @(posedge pclk) disable iff (!presetn)
      acc && !pwrite && paddr == SMC_CTRL_OFS |-> prdata == {16'h0000, ctrl_q};
  endproperty
  property p_resv;
    @(posedge pclk) disable iff (!presetn)
      acc && !pwrite && paddr == SMC_CTRL_OFS |-> (prdata[15:0] & ~RW_BITS) == 16'h0000;
  endproperty
  property p_unmap;
    @(posedge pclk) disable iff (!presetn)
      acc && (paddr > SMC_STAT_OFS || paddr[1:0] != 2'b00) |->
        pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_tx_ref;
    @(posedge pclk) disable iff (!presetn)
      acc && pwrite && paddr == SMC_TXD_OFS && !ctrl_q[15] |-> pslverr;
  endproperty
  property p_off_sel;
    @(posedge link_clk) disable iff (!presetn)
      stab_q == 4'hF && !ctrl_q[15] |-> slave_select_zero_n;
  endproperty
  property p_off_sck;
    @(posedge link_clk) disable iff (!presetn)
      stab_q == 4'hF && !ctrl_q[15] |-> sck == ctrl_q[12];
  endproperty
  property p_frame;
    @(posedge link_clk) disable iff (!presetn)
      $fell(slave_select_zero_n) |=> !slave_select_zero_n [*8];
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
  a_resv: assert property (p_resv) else $error("reserved bit set");
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
  a_tx_ref: assert property (p_tx_ref) else $error("tx taken in codec mode");
  a_off_sel: assert property (p_off_sel) else $error("select low in codec mode");
  a_off_sck: assert property (p_off_sck) else $error("idle clock level wrong");
  a_frame: assert property (p_frame) else $error("frame select too short");
  c_ctrl_wr: cover property (@(posedge pclk) acc && pwrite && paddr == SMC_CTRL_OFS);
  c_unmap: cover property (@(posedge pclk) acc && paddr == 8'h14);
  c_frame: cover property (@(posedge link_clk) $fell(slave_select_zero_n));
endmodule : smc_spi_master_assertions

bind smc_spi_master smc_spi_master_assertions smc_spi_master_assertions_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .link_clk(link_clk), .sck(sck),
  .slave_select_zero_n(slave_select_zero_n)
);

// file: sim/smc_spi_master_tb.sv
// testbench for the spi mode control block
`timescale 1ns/1ps
module smc_spi_master_tb;
  import smc_pkg::*;
  localparam int  DIVN = 4;
  localparam real HP   = (DIVN + 1) * 64.0;
  logic        pclk, presetn, psel, penable, pwrite, link_clk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, err, sck, ss_n, mosi, miso, clock_phase_select, clock_polarity_select, first;
  logic [15:0] reply, w1;
  int          n_fail, check_count, nr, nf, n0, p, q, c, i;
  realtime     t_fall, t_rise, t_su, t_last, t_gap;
  // ==========================================================
  // design and slave
  smc_spi_master smc_spi_master_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_clk(link_clk), .sck(sck), .slave_select_zero_n(ss_n),
    .mosi(mosi), .miso(miso)
  );
  smc_slave_model smc_slave_model_inst (
    .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso), .clock_phase_select(clock_phase_select), .clock_polarity_select(clock_polarity_select),
    .reply(reply)
  );
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #32 link_clk = ~link_clk;
  end
  // ==========================================================
  // link timing monitor; zero setup means clock and select move together
  always @(negedge ss_n) begin
    t_gap = $realtime - t_rise;
    t_fall = $realtime;
    first = (t_last != $realtime);
    t_su = 0;
    nf++;
  end
  always @(sck) begin
    if (!ss_n && first) t_su = $realtime - t_fall;
    first = 1'b0;
    t_last = $realtime;
  end
  always @(posedge ss_n) begin
    if (presetn === 1'b1) begin
      t_rise = $realtime;
      nr++;
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until pready is seen high at a rising edge; answer taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      apb(1'b0, SMC_STAT_OFS, 32'h0);
      k++;
    end while ((rd & m) !== v && k < 3000);
    chk(rd & m, v);
  endtask : wait_stat
  task automatic end_sim;
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial begin
    #1_000_000;
    n_fail++;
    end_sim();
  end
  // ==========================================================
  // tests
  initial begin
    {psel, penable, pwrite, presetn, clock_phase_select, clock_polarity_select, first} = 7'h0;
    {paddr, pwdata, reply} = 56'h0;
    pstrb = 4'hF;
    {n_fail, check_count, nr, nf} = 128'h0;
    t_rise = 0;
    t_last = 0;
    repeat (2) @(posedge pclk);
    repeat (3) @(posedge link_clk);
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, SMC_CTRL_OFS, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b1, SMC_CTRL_OFS, 32'hFFFF_FFFF);
    apb(1'b0, SMC_CTRL_OFS, 32'h0);
    chk(rd, 32'h0000_B133);
    apb(1'b1, 8'h14, 32'h1);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, SMC_CTRL_OFS, 32'h0000_0100);
    apb(1'b1, SMC_TXD_OFS, 32'h0000_1234);
    chk({31'h0, err}, 32'h1);
    repeat (200) @(posedge pclk);
    chk(32'(nf), 32'h0);
    apb(1'b1, SMC_DIV_OFS, 32'(DIVN));
    for (p = 0; p < 2; p++) begin
      for (q = 0; q < 2; q++) begin
        for (c = 0; c < 4; c++) begin
          clock_phase_select = p[0];
          clock_polarity_select = q[0];
          w1 = 16'hC35A ^ {12'h0, p[0], q[0], c[1:0]};
          reply = ~w1 ^ 16'h0F0F;
          apb(1'b1, SMC_CTRL_OFS, {16'h0, 2'b10, p[0], q[0], 4'h1, 2'b00, c[1:0], 2'b00, c[1:0]});
          repeat (60) @(posedge pclk);
          chk({31'h0, sck}, {31'h0, clock_polarity_select});
          n0 = nr;
          apb(1'b1, SMC_TXD_OFS, {16'h0, w1});
          wait_stat(32'h1, 32'h0);
          apb(1'b1, SMC_TXD_OFS, {16'h0, ~w1});
          for (i = 0; i < 4000 && smc_slave_model_inst.got.size() < 2; i++) @(posedge pclk);
          wait_stat(32'h7, 32'h4);
          chk(32'(int'(t_su / HP)), 32'(c + 1 - p));
          chk(32'(int'((t_rise - t_last) / HP)), 32'(c + p));
          chk(32'(nr - n0), (c == 0) ? 32'h1 : 32'h2);
          chk({31'h0, (t_gap >= 2 * c * HP) || c == 0}, 32'h1);
          chk(32'(smc_slave_model_inst.got.size()), 32'h2);
          if (smc_slave_model_inst.got.size() == 2) begin
            chk({16'h0, smc_slave_model_inst.got.pop_front()}, {16'h0, w1});
            chk({16'h0, smc_slave_model_inst.got.pop_front()}, {16'h0, ~w1});
          end
          smc_slave_model_inst.got.delete();
          apb(1'b0, SMC_RXD_OFS, 32'h0);
          chk(rd, {16'h0, reply});
        end
      end
    end
    apb(1'b1, SMC_CTRL_OFS, 32'h0000_8000);
    n0 = nf;
    apb(1'b1, SMC_TXD_OFS, 32'h0000_9696);
    wait_stat(32'h7, 32'h4);
    chk(32'(nf - n0), 32'h0);
    end_sim();
  end
endmodule : smc_spi_master_tb
